// *** src/sieb_top.sv ***
// Configurable safety input evaluator with a Wishbone register slave
`timescale 1ns/100ps

// Summary of operation
// - Pedal output true only while pressed
// - Pedal: NC, NO, double NC, NO plus NC
// - Mixed pedal: first NO, second NC
// - Reset enabled: reset needed after each pedal or photocell activation
// - Manual on rise, monitored on rise-then-fall
// - Reset pin follows last used input
// - Test pulses drive contacts, returns checked
// - Start-up test needs one press-release cycle
// - Debounce filter 3 to 250 ms
// - Optional pedal simultaneity time check
// - Optional fault output per block
// - Selector: single true input selects output
// - Selector always checks simultaneity
// - Photocell output follows clear beam
// - Photocell always uses one test line
// - Two-hand needs both presses within 500 ms
// - Two-hand: two NO or four NO/NC
// - Two-hand start-up: press within 500 ms, release
// - Network output follows line level
// - Network: single or dual line
// - Network block only on master module
module sieb_top import sieb_pkg::*; #(
	parameter int TICKS_PER_MS = TICKS_PER_MS_DEF,
	parameter logic MASTER_MODULE = 1'b1
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [4:0] fieldIn,
	output logic [3:0] testOut,
	output logic blockOut,
	output logic [3:0] selOut,
	output logic faultOut,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Byte-lane merge of a Wishbone write into an old word
	function automatic logic [31:0] wbMerge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Position of the reset pin: the one after the block's last input
	function automatic logic [2:0] rstIndex(input logic [2:0] kind, input logic [1:0] itype);
		logic [2:0] r;
		r = NO_RESET_PIN;
		if (kind == KIND_PHOTOCELL) begin
			r = 3'h1;
		end else if (kind == KIND_PEDAL) begin
			r = (itype == PEDAL_NC || itype == PEDAL_NO) ? 3'h1 : 3'h2;
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic [1:0] rstSync_ff;
	logic rstN;

	// Asynchronous assert, release after two edges
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rstSync_ff <= 2'h0;
		end else begin
			rstSync_ff <= {rstSync_ff[0], 1'b1};
		end
	end
	assign rstN = rstSync_ff[1];

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	sieb_state_t st_ff, nxt_st;
	logic [4:0] f;
	logic [3:0] v, selMask, testMask, lineUsed;
	logic ch0, ch1, active, inactive, disc, chk, cfgErr, discHit, faultEvt;
	logic rstPin, rstRise, rstFall, rstAccept, rstUsable;
	logic [9:0] limit;
	logic [2:0] rIdx;
	logic [31:0] rd, wr;

	always_comb begin
		nxt_st = st_ff;
		f = st_ff.filt;
		ch0 = 1'b0;
		ch1 = 1'b0;
		active = 1'b0;
		inactive = 1'b0;
		disc = 1'b0;
		chk = 1'b0;
		cfgErr = 1'b0;
		limit = {2'h0, st_ff.simulMs};
		selMask = (st_ff.ctrl.itype == SEL_TWO) ? 4'h3 :
			(st_ff.ctrl.itype == SEL_THREE) ? 4'h7 : 4'hf;
		v = 4'h0;
		rd = 32'h0;
		wr = 32'h0;

		// Pins pass two flops before anything reads them
		nxt_st.syncA = fieldIn;
		nxt_st.syncB = st_ff.syncA;

		// Millisecond time base shared by filter, timers and test pulses
		nxt_st.msTick = 1'b0;
		if (st_ff.tick == 16'(TICKS_PER_MS - 1)) begin
			nxt_st.tick = 16'h0;
			nxt_st.msTick = 1'b1;
		end else begin
			nxt_st.tick = st_ff.tick + 16'h1;
		end

		// Lines in use; the photocell always checks its first input
		testMask = 4'h0;
		lineUsed = 4'h0;
		for (int i = 0; i < 4; i++) begin
			testMask[i] = st_ff.testMap[i*TESTMAP_BITS + 2] |
				(i == 0 && st_ff.ctrl.kind == KIND_PHOTOCELL);
			if (testMask[i]) begin
				lineUsed[st_ff.testMap[i*TESTMAP_BITS +: 2]] = 1'b1;
			end
		end

		// periodic low pulse; a closed contact must follow it
		if (st_ff.msTick) begin
			nxt_st.testMs = (st_ff.testMs == TEST_PERIOD_MS - 8'h1) ? 8'h0 :
				st_ff.testMs + 8'h1;
		end
		nxt_st.testPulse = nxt_st.testMs < TEST_PULSE_MS;
		nxt_st.testFail = 1'b0;
		if (nxt_st.testPulse && !st_ff.testPulse) begin
			nxt_st.heldHigh = st_ff.syncB[3:0] & testMask;
			nxt_st.sawLow = 4'h0;
		end else if (st_ff.testPulse) begin
			nxt_st.sawLow = st_ff.sawLow | (~st_ff.syncB[3:0] & testMask);
		end
		if (st_ff.testPulse && !nxt_st.testPulse) begin
			nxt_st.testFail = |(st_ff.heldHigh & ~nxt_st.sawLow);
		end
		nxt_st.testOut = lineUsed & ~{4{nxt_st.testPulse}};

		// accept a level after it stood for the filter time
		// Pulsed inputs are frozen, since a 20 ms pulse outlasts short filters
		for (int i = 0; i < 5; i++) begin
			if (st_ff.syncB[i] == st_ff.filt[i] ||
				(i < 4 && testMask[i % 4] && st_ff.testPulse)) begin
				nxt_st.fcnt[i] = 8'h0;
			end else if (st_ff.fcnt[i] >= st_ff.filterMs) begin
				nxt_st.filt[i] = st_ff.syncB[i];
				nxt_st.fcnt[i] = 8'h0;
			end else if (st_ff.msTick) begin
				nxt_st.fcnt[i] = st_ff.fcnt[i] + 8'h1;
			end
		end

		// Per-kind evaluation of the filtered contacts
		case (st_ff.ctrl.kind)
			KIND_PEDAL: begin
				// first input NO, second NC in mixed wiring
				ch0 = (st_ff.ctrl.itype == PEDAL_NO || st_ff.ctrl.itype == PEDAL_NONC) ?
					f[0] : ~f[0];
				ch1 = (st_ff.ctrl.itype == PEDAL_2NC || st_ff.ctrl.itype == PEDAL_NONC) ?
					~f[1] : ch0;
				active = ch0 & ch1;
				inactive = ~ch0 & ~ch1;
				disc = ch0 ^ ch1;
				chk = st_ff.ctrl.simulEn;
			end
			KIND_SELECTOR: begin
				v = f[3:0] & selMask;
				active = $onehot(v);
				inactive = active;
				disc = ~active;
				chk = 1'b1;
			end
			KIND_PHOTOCELL: begin
				active = f[0];
				inactive = ~f[0];
			end
			KIND_TWOHAND: begin
				// quad wiring: NO closed and NC open per button
				ch0 = (st_ff.ctrl.itype == HAND_QUAD) ? f[0] & ~f[1] : f[0];
				ch1 = (st_ff.ctrl.itype == HAND_QUAD) ? f[2] & ~f[3] : f[1];
				active = ch0 & ch1;
				inactive = ~ch0 & ~ch1;
				disc = ch0 ^ ch1;
				// second press within the fixed window
				chk = 1'b1;
				limit = TWOHAND_MS;
			end
			KIND_NETWORK: begin
				// line level, one or two lines
				ch1 = (st_ff.ctrl.itype == NET_SINGLE) ? f[0] : f[1];
				active = f[0] & ch1;
				inactive = ~f[0] & ~ch1;
				disc = f[0] ^ ch1;
				chk = st_ff.ctrl.simulEn;
				cfgErr = !MASTER_MODULE;
			end
			default: begin
				cfgErr = 1'b1;
			end
		endcase

		// mismatch timer, test failure or bad setup give a fault
		if (disc && chk && st_ff.state != ST_FAULT) begin
			if (st_ff.msTick && st_ff.discMs != 10'h3ff) begin
				nxt_st.discMs = st_ff.discMs + 10'h1;
			end
		end else begin
			nxt_st.discMs = 10'h0;
		end
		discHit = disc && chk && (st_ff.discMs >= limit);
		faultEvt = discHit | st_ff.testFail | cfgErr;

		// reset contact sits after the block's inputs
		rIdx = rstIndex(st_ff.ctrl.kind, st_ff.ctrl.itype);
		rstPin = (rIdx == NO_RESET_PIN) ? 1'b0 : f[rIdx];
		rstUsable = st_ff.ctrl.rstEn && (rIdx != NO_RESET_PIN);
		rstRise = rstPin & ~st_ff.rstPrev;
		rstFall = ~rstPin & st_ff.rstPrev;
		nxt_st.rstPrev = rstPin;
		// monitored needs the rise seen while waiting, then the fall
		rstAccept = st_ff.ctrl.rstMon ? (rstFall & st_ff.rstHigh) : rstRise;
		nxt_st.rstHigh = (st_ff.state == ST_WAITRST) && (st_ff.rstHigh | rstRise);

		// Evaluator sequence
		case (st_ff.state)
			ST_START: begin
				// one full activate-and-release after power-up
				// Without the test the block runs, but the test stays pending
				if (!st_ff.ctrl.startEn) begin
					nxt_st.state = ST_SAFE;
				end else if (st_ff.sawActive && inactive) begin
					nxt_st.state = ST_SAFE;
					nxt_st.startupDone = 1'b1;
				end
				nxt_st.sawActive = st_ff.sawActive | (active & st_ff.ctrl.startEn);
			end
			ST_SAFE: begin
				// reset request on each activation when enabled, for pedal and photocell only
				if (active) begin
					nxt_st.state = rstUsable ? ST_WAITRST : ST_ON;
				end
			end
			ST_WAITRST: begin
				if (!active) begin
					nxt_st.state = ST_SAFE;
				end else if (rstAccept) begin
					nxt_st.state = ST_ON;
				end
			end
			ST_ON: begin
				if (!active) begin
					nxt_st.state = ST_SAFE;
				end
			end
			ST_FAULT: begin
				// Leave only from the rest position; start-up test is kept once done
				if (inactive && !cfgErr) begin
					nxt_st.state = st_ff.startupDone ? ST_SAFE : ST_START;
				end
			end
			default: begin
				nxt_st.state = ST_FAULT;
			end
		endcase
		if (st_ff.ctrl.startEn && !nxt_st.startupDone && st_ff.state != ST_FAULT) begin
			nxt_st.state = ST_START;
		end
		if (faultEvt) begin
			nxt_st.state = ST_FAULT;
		end

		// Registered outputs
		nxt_st.out = nxt_st.state == ST_ON;
		nxt_st.selOut = (nxt_st.state == ST_ON && st_ff.ctrl.kind == KIND_SELECTOR) ? v : 4'h0;
		nxt_st.fault = (nxt_st.state == ST_FAULT) && st_ff.ctrl.errEn;

		// Wishbone slave: ack one cycle after the request, one cycle long
		nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
		case (wb_adr_i)
			OFS_CTRL: rd = {22'h0, st_ff.ctrl};
			OFS_FILTER: rd = {24'h0, st_ff.filterMs};
			OFS_SIMUL: rd = {24'h0, st_ff.simulMs};
			OFS_TESTMAP: rd = {20'h0, st_ff.testMap};
			OFS_STATUS: rd = {15'h0, st_ff.startupDone, st_ff.filt, st_ff.state,
				st_ff.fault, st_ff.selOut, st_ff.out};
			default: rd = 32'h0;
		endcase
		nxt_st.rdat = nxt_st.ack ? rd : 32'h0;
		// Write lands on the edge where the master sees ack
		if (wb_cyc_i && wb_stb_i && wb_we_i && st_ff.ack) begin
			wr = wbMerge(rd, wb_dat_i, wb_sel_i);
			case (wb_adr_i)
				OFS_CTRL: nxt_st.ctrl = wr[9:0];
				OFS_FILTER: begin
					// Out-of-range filter times are clamped, never refused
					nxt_st.filterMs = (wr[7:0] < FILTER_MIN_MS) ? FILTER_MIN_MS :
						(wr[7:0] > FILTER_MAX_MS) ? FILTER_MAX_MS : wr[7:0];
				end
				OFS_SIMUL: nxt_st.simulMs = wr[7:0];
				OFS_TESTMAP: nxt_st.testMap = wr[11:0];
				default: nxt_st.rdat = 32'h0;
			endcase
		end
		if (nxt_st.ctrl.startEn && !nxt_st.startupDone) begin
			nxt_st.out = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	// Fields are set one by one so reset holds constants only
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			st_ff <= '0;
			st_ff.state <= ST_START;
			st_ff.ctrl <= CTRL_RST;
			st_ff.filterMs <= FILTER_RST;
			st_ff.simulMs <= SIMUL_RST;
			st_ff.testMap <= TESTMAP_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign testOut = st_ff.testOut;
	assign blockOut = st_ff.out;
	assign selOut = st_ff.selOut;
	assign faultOut = st_ff.fault;
	assign wb_dat_o = st_ff.rdat;
	assign wb_ack_o = st_ff.ack;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstN);

	a_pedal_released: assert property (
		(st_ff.ctrl.kind == KIND_PEDAL && inactive) [*2] |-> !blockOut)
		else $error("pedal output high while released");
	a_mixed_wiring: assert property (
		(st_ff.ctrl.kind == KIND_PEDAL && st_ff.ctrl.itype == PEDAL_NONC && f[0] && !f[1]
		&& st_ff.state == ST_SAFE && !st_ff.ctrl.rstEn && !faultEvt) |=> ##1 blockOut)
		else $error("mixed pedal not taken as pressed");
	a_reset_wait: assert property (
		(st_ff.state == ST_WAITRST && !rstAccept) |=> st_ff.state != ST_ON)
		else $error("output enabled without reset");
	a_manual_edge: assert property (
		(st_ff.state == ST_WAITRST && active && !st_ff.ctrl.rstMon && rstRise && !faultEvt)
		|=> st_ff.state == ST_ON)
		else $error("manual reset edge ignored");
	a_startup_hold: assert property (
		(st_ff.ctrl.startEn && !st_ff.startupDone) |-> !blockOut)
		else $error("output before start-up test");
	a_filter_stable: assert property (
		$changed(st_ff.filt[0]) |-> $past(st_ff.syncB[0], 2) == st_ff.filt[0])
		else $error("filter took an unsettled level");
	a_fault_gate: assert property (
		faultOut |-> (st_ff.state == ST_FAULT && st_ff.ctrl.errEn))
		else $error("fault output without enabled fault");
	a_sel_single: assert property (
		$onehot0(selOut))
		else $error("selector drove several outputs");
	a_photo_line: assert property (
		(st_ff.ctrl.kind == KIND_PHOTOCELL && st_ff.testPulse && $stable(st_ff.testMap))
		|-> !testOut[st_ff.testMap[1:0]])
		else $error("photocell test line not pulsed");
	a_late_fault: assert property (
		(discHit && st_ff.state != ST_FAULT) |=> st_ff.state == ST_FAULT ##1 !blockOut)
		else $error("timing fault not latched");

	c_pedal_on: cover property (st_ff.ctrl.kind == KIND_PEDAL && $rose(blockOut));
	c_twohand_late: cover property (st_ff.ctrl.kind == KIND_TWOHAND && $rose(faultOut));
	c_test_fail: cover property (st_ff.testFail);
	c_sel_pos: cover property ($rose(selOut[2]));

endmodule

// *** common/sieb_pkg.sv ***
// Shared constants and types of the safety input evaluation block
package sieb_pkg;

	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_FREQ_HZ = 20_000_000;
	localparam int MS_PER_S = 1000;
	localparam int TICKS_PER_MS_DEF = CLK_FREQ_HZ / MS_PER_S;
	localparam logic [7:0] FILTER_MIN_MS = 8'h03;
	localparam logic [7:0] FILTER_MAX_MS = 8'hfa;
	localparam logic [9:0] TWOHAND_MS = 10'h1f4;
	localparam logic [7:0] TEST_PERIOD_MS = 8'hfa;
	localparam logic [7:0] TEST_PULSE_MS = 8'h14;

	// ---------------------------------------------------------------
	// Register map and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FILTER = 8'h04;
	localparam logic [7:0] OFS_SIMUL = 8'h08;
	localparam logic [7:0] OFS_TESTMAP = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [9:0] CTRL_RST = 10'h000;
	localparam logic [7:0] FILTER_RST = 8'h03;
	localparam logic [7:0] SIMUL_RST = 8'h64;
	localparam logic [11:0] TESTMAP_RST = 12'h000;
	localparam int TESTMAP_BITS = 3;

	// ---------------------------------------------------------------
	// Block kinds and input types
	// ---------------------------------------------------------------
	localparam logic [2:0] KIND_PEDAL = 3'h0;
	localparam logic [2:0] KIND_SELECTOR = 3'h1;
	localparam logic [2:0] KIND_PHOTOCELL = 3'h2;
	localparam logic [2:0] KIND_TWOHAND = 3'h3;
	localparam logic [2:0] KIND_NETWORK = 3'h4;
	localparam logic [1:0] PEDAL_NC = 2'h0;
	localparam logic [1:0] PEDAL_NO = 2'h1;
	localparam logic [1:0] PEDAL_2NC = 2'h2;
	localparam logic [1:0] PEDAL_NONC = 2'h3;
	localparam logic [1:0] SEL_TWO = 2'h0;
	localparam logic [1:0] SEL_THREE = 2'h1;
	localparam logic [1:0] HAND_2NO = 2'h0;
	localparam logic [1:0] HAND_QUAD = 2'h1;
	localparam logic [1:0] NET_SINGLE = 2'h0;
	localparam logic [2:0] NO_RESET_PIN = 3'h7;

	// Control word layout
	typedef struct packed {
		logic errEn;
		logic simulEn;
		logic startEn;
		logic rstMon;
		logic rstEn;
		logic [1:0] itype;
		logic [2:0] kind;
	} sieb_ctrl_t;

	// Evaluator states, one-hot
	typedef enum logic [4:0] {
		ST_START = 5'b00001,
		ST_SAFE = 5'b00010,
		ST_WAITRST = 5'b00100,
		ST_ON = 5'b01000,
		ST_FAULT = 5'b10000
	} sieb_fsm_t;

	// Whole state of the block
	typedef struct packed {
		logic [4:0] syncA;
		logic [4:0] syncB;
		logic [4:0] filt;
		logic [4:0][7:0] fcnt;
		logic [15:0] tick;
		logic msTick;
		logic [9:0] discMs;
		logic [7:0] testMs;
		logic testPulse;
		logic [3:0] heldHigh;
		logic [3:0] sawLow;
		logic testFail;
		sieb_fsm_t state;
		logic startupDone;
		logic sawActive;
		logic rstHigh;
		logic rstPrev;
		sieb_ctrl_t ctrl;
		logic [7:0] filterMs;
		logic [7:0] simulMs;
		logic [11:0] testMap;
		logic ack;
		logic [31:0] rdat;
		logic out;
		logic [3:0] selOut;
		logic fault;
		logic [3:0] testOut;
	} sieb_state_t;

endpackage

// *** tb/sieb_field_model.sv ***
// Field devices: contacts, reset button and photocell powered by test lines
`timescale 1ns/100ps
module sieb_field_model import sieb_pkg::*; #(
	parameter int RESP_CYC = 100
) (
	input wire logic ref_clk,
	input wire logic [3:0] testOut,
	input wire logic [11:0] testMap,
	input wire logic [4:0] closed,
	input wire logic [4:0] shortHi,
	output logic [4:0] fieldIn
);
	int lowCnt [4] = '{default: 0};
	logic [3:0] quiet = 4'h0;

	// A device sees its test line drop only after its own response time
	// late test answer
	always @(posedge ref_clk) begin
		for (int l = 0; l < 4; l++) begin
			lowCnt[l] <= testOut[l] ? 0 : lowCnt[l] + 1;
			quiet[l] <= !testOut[l] && lowCnt[l] >= RESP_CYC;
		end
	end

	// Tested contacts carry their line's level; a short to supply overrides it
	// test loopback wiring
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			fieldIn[i] = (closed[i] & ~(testMap[3 * i + 2] & quiet[testMap[3 * i +: 2]]))
				| shortHi[i];
		end
		fieldIn[4] = closed[4] | shortHi[4];
	end
endmodule

// *** tb/test_safety_input_evaluation_blocks.sv ***
// Bench for the safety input evaluator: register access and field scenarios
`timescale 1ns/100ps
module test_safety_input_evaluation_blocks import sieb_pkg::*;;
	localparam int TPM = 20;
	logic ref_clk;
	logic resetn;
	logic [4:0] closed;
	logic [4:0] shortHi;
	logic [11:0] testMap;
	logic [4:0] fieldIn;
	logic [3:0] testOut;
	logic blockOut;
	logic [3:0] selOut;
	logic faultOut;
	logic cyc;
	logic stb;
	logic we;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] datI;
	logic [31:0] datO;
	logic ack;
	int failures;
	int numChecks;
	// Rest and pressed patterns per pedal type: NC, NO, double NC, NO plus NC
	logic [4:0] restP [4] = '{5'h01, 5'h00, 5'h03, 5'h02};
	logic [4:0] pressP [4] = '{5'h00, 5'h01, 5'h00, 5'h01};

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	sieb_top #(.TICKS_PER_MS(TPM), .MASTER_MODULE(1'b1)) sieb_top_i (
		.ref_clk(ref_clk), .resetn(resetn), .fieldIn(fieldIn), .testOut(testOut),
		.blockOut(blockOut), .selOut(selOut), .faultOut(faultOut), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
		.wb_dat_o(datO), .wb_ack_o(ack)
	);

	sieb_field_model #(.RESP_CYC(5 * TPM)) sieb_field_model_i (
		.ref_clk(ref_clk), .testOut(testOut), .testMap(testMap), .closed(closed),
		.shortHi(shortHi), .fieldIn(fieldIn)
	);

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ms(input int n);
		repeat (n * TPM) @(posedge ref_clk);
	endtask

	// One classic cycle; request held until ack is sampled, then one idle cycle
	task automatic wbx(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datI <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1) begin
			chk(ack, 1);
			end_of_test();
		end
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wbx(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wbx(a, 1'b0, 32'h0, q);
		chk(q, exp);
	endtask

	// Bounded wait for a test line level; a full period plus margin
	task automatic waitLine(input int k, input logic lvl);
		int n;
		n = 0;
		while (testOut[k] !== lvl && n < 6000) begin
			@(posedge ref_clk);
			n++;
		end
		if (testOut[k] !== lvl) begin
			chk(testOut[k], lvl);
			end_of_test();
		end
	endtask

	function automatic logic [31:0] cw(input logic [2:0] k, input logic [1:0] it,
		input logic [4:0] f);
		return {22'h0, f, it, k};
	endfunction

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hf;
		datI = 32'h0;
		closed = 5'h00;
		shortHi = 5'h00;
		testMap = 12'h000;
		failures = 0;
		numChecks = 0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		// Reset values, an unmapped place and the filter clamp
		rd(OFS_CTRL, 32'h0);
		rd(OFS_FILTER, 32'h3);
		rd(OFS_SIMUL, 32'h64);
		rd(OFS_TESTMAP, 32'h0);
		rd(8'h20, 32'h0);
		wr(OFS_FILTER, 32'h1);
		rd(OFS_FILTER, 32'h3);
		wr(OFS_FILTER, 32'hff);
		rd(OFS_FILTER, 32'hfa);
		wr(OFS_FILTER, 32'h3);
		// Every pedal type: rest gives 0, pressed gives 1 after the filter
		for (int t = 0; t < 4; t++) begin
			closed <= restP[t];
			wr(OFS_CTRL, cw(KIND_PEDAL, 2'(t), 5'h10));
			ms(6);
			chk(blockOut, 0);
			closed <= pressP[t];
			repeat (35) @(posedge ref_clk);
			chk(blockOut, 0);
			ms(4);
			chk(blockOut, 1);
			closed <= restP[t];
			ms(6);
			chk(blockOut, 0);
		end
		// Manual then monitored reset on the input after the pedal's
		for (int m = 0; m < 2; m++) begin
			closed <= 5'h00;
			wr(OFS_CTRL, cw(KIND_PEDAL, PEDAL_NO, m ? 5'h13 : 5'h11));
			ms(6);
			closed <= 5'h01;
			ms(6);
			chk(blockOut, 0);
			closed <= 5'h03;
			ms(6);
			chk(blockOut, 32'(m == 0));
			closed <= 5'h01;
			ms(6);
			chk(blockOut, 1);
			closed <= 5'h00;
			ms(6);
			closed <= 5'h01;
			ms(6);
			chk(blockOut, 0);
		end
		// Pedal channels disagree too long: fault until both are at rest
		wr(OFS_SIMUL, 32'ha);
		closed <= 5'h03;
		wr(OFS_CTRL, cw(KIND_PEDAL, PEDAL_2NC, 5'h18));
		ms(6);
		closed <= 5'h02;
		ms(20);
		chk(faultOut, 1);
		closed <= 5'h00;
		ms(6);
		chk(blockOut, 0);
		closed <= 5'h03;
		ms(6);
		chk(faultOut, 0);
		// Selector: one position at a time, two at once blank then fault
		closed <= 5'h01;
		wr(OFS_CTRL, cw(KIND_SELECTOR, 2'h2, 5'h10));
		ms(6);
		for (int i = 0; i < 4; i++) begin
			closed <= 5'(1 << i);
			ms(6);
			chk(selOut, 1 << i);
		end
		closed <= 5'h09;
		ms(6);
		chk(selOut, 0);
		ms(10);
		chk(faultOut, 1);
		closed <= 5'h01;
		ms(6);
		chk(selOut, 1);
		// Photocell on each test line: pulses answered late still pass
		for (int k = 0; k < 4; k++) begin
			closed <= 5'h00;
			testMap <= 12'(4 + k);
			wr(OFS_TESTMAP, 32'(4 + k));
			wr(OFS_CTRL, cw(KIND_PHOTOCELL, 2'h0, 5'h10));
			waitLine(k, 1'b0);
			waitLine(k, 1'b1);
			closed <= 5'h01;
			ms(6);
			chk(testOut, 1 << k);
			chk(blockOut, 1);
			waitLine(k, 1'b0);
			ms(25);
			chk(faultOut, 0);
			chk(blockOut, 1);
			closed <= 5'h00;
			ms(6);
			chk(blockOut, 0);
		end
		// A line shorted to supply never answers the pulse
		closed <= 5'h01;
		shortHi <= 5'h01;
		ms(6);
		waitLine(3, 1'b0);
		waitLine(3, 1'b1);
		ms(2);
		chk(faultOut, 1);
		chk(blockOut, 0);
		shortHi <= 5'h00;
		closed <= 5'h00;
		ms(6);
		chk(faultOut, 0);
		testMap <= 12'h000;
		wr(OFS_TESTMAP, 32'h0);
		// Two-hand, both wirings: 50 ms apart passes, 520 ms apart faults
		for (int t = 0; t < 2; t++) begin
			closed <= t ? 5'h0a : 5'h00;
			wr(OFS_CTRL, cw(KIND_TWOHAND, 2'(t), 5'h10));
			ms(6);
			closed <= t ? 5'h09 : 5'h01;
			ms(50);
			closed <= t ? 5'h05 : 5'h03;
			ms(6);
			chk(blockOut, 1);
			closed <= t ? 5'h0a : 5'h00;
			ms(6);
			closed <= t ? 5'h09 : 5'h01;
			ms(520);
			chk(faultOut, 1);
			closed <= t ? 5'h05 : 5'h03;
			ms(6);
			chk(blockOut, 0);
			closed <= t ? 5'h0a : 5'h00;
			ms(6);
			chk(faultOut, 0);
		end
		// Network input follows its line, single and dual
		for (int t = 0; t < 2; t++) begin
			wr(OFS_CTRL, cw(KIND_NETWORK, 2'(t), 5'h10));
			closed <= t ? 5'h03 : 5'h01;
			ms(6);
			chk(blockOut, 1);
			closed <= 5'h00;
			ms(6);
			chk(blockOut, 0);
		end
		// Fresh power-up: the first two-hand press must be released first
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		wr(OFS_CTRL, cw(KIND_TWOHAND, HAND_2NO, 5'h14));
		ms(6);
		closed <= 5'h03;
		ms(6);
		chk(blockOut, 0);
		closed <= 5'h00;
		ms(6);
		closed <= 5'h03;
		ms(6);
		chk(blockOut, 1);
		end_of_test();
	end
endmodule
